/* rtl/cantrs_pkg.sv */
package cantrs_pkg;
    // register map of the request/status pair
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam int          NUM_BUF          = 8;
    localparam int          HALF             = 4;
    localparam logic [7:0]  TX_CMD_STATUS_LOWER = 8'h05;
    localparam logic [7:0]  TX_CMD_STATUS_UPPER = 8'h06;
    localparam logic [7:0]  TX_STATUS_RESET  = 8'h0F;
    // field positions inside either register
    localparam int          FLD_BUSY_LSB     = 4;
    localparam int          FLD_DONE_LSB     = 0;
    localparam int          FLD_ABORT_LSB    = 4;
    localparam int          FLD_SEND_LSB     = 0;
    // per-buffer reset values
    localparam logic [7:0]  BUSY_RESET       = 8'h00;
    localparam logic [7:0]  DONE_RESET       = 8'hFF;
    // buffer index width
    localparam int          IDX_W            = 3;
    typedef enum logic [1:0] {CANTRS_IDLE, CANTRS_SENDING} cantrs_state_t;
endpackage : cantrs_pkg

/* rtl/cantrs_tx_request_status.sv */
`timescale 1ns/1ps
module cantrs_tx_request_status
    import cantrs_pkg::*;
(
    input  wire logic                          clk_in,
    input  wire logic                          reset_n_in,
    input  wire logic [cantrs_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [cantrs_pkg::DATA_W-1:0] reg_wdata_in,
    input  wire logic                          reg_write_in,
    input  wire logic                          reg_read_in,
    output logic      [cantrs_pkg::DATA_W-1:0] reg_rdata_out,
    input  wire logic [cantrs_pkg::NUM_BUF-1:0] auto_dispatch_enable_in,
    input  wire logic [cantrs_pkg::NUM_BUF-1:0] dispatch_due_in,
    output logic      [cantrs_pkg::NUM_BUF-1:0] tx_start_out,
    output logic      [cantrs_pkg::NUM_BUF-1:0] tx_abort_out,
    input  wire logic [cantrs_pkg::NUM_BUF-1:0] tx_active_in,
    input  wire logic [cantrs_pkg::NUM_BUF-1:0] tx_success_in,
    input  wire logic [cantrs_pkg::NUM_BUF-1:0] tx_abort_done_in,
    output logic      [cantrs_pkg::NUM_BUF-1:0] tx_buffer_busy_out,
    output logic      [cantrs_pkg::NUM_BUF-1:0] tx_done_flag_out
);
    import cantrs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [NUM_BUF-1:0] pending;
    logic [NUM_BUF-1:0] next_pending;
    logic [NUM_BUF-1:0] tx_buffer_busy;
    logic [NUM_BUF-1:0] next_tx_buffer_busy;
    logic [NUM_BUF-1:0] tx_done_flag;
    logic [NUM_BUF-1:0] next_tx_done_flag;
    logic [NUM_BUF-1:0] tx_abort;
    logic [NUM_BUF-1:0] next_tx_abort;
    logic [NUM_BUF-1:0] tx_start;
    logic [NUM_BUF-1:0] next_tx_start;
    logic [DATA_W-1:0]  rdata;
    logic [DATA_W-1:0]  next_rdata;
    cantrs_state_t      state;
    cantrs_state_t      next_state;
    logic [NUM_BUF-1:0] send_cmd;
    logic [NUM_BUF-1:0] abort_cmd;
    logic [NUM_BUF-1:0] start_req;
    logic [NUM_BUF-1:0] grant;

    // one-hot pick of the lowest set bit
    function automatic logic [NUM_BUF-1:0] lowest_first(input logic [NUM_BUF-1:0] v);
        logic [NUM_BUF-1:0] r;
        r = '0;
        for (int i = NUM_BUF - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : lowest_first

    // status byte for one half of the buffers
    function automatic logic [DATA_W-1:0] status_byte(input logic [HALF-1:0] busy,
                                                      input logic [HALF-1:0] done);
        logic [DATA_W-1:0] r;
        r = '0;
        r[FLD_BUSY_LSB +: HALF] = busy;
        r[FLD_DONE_LSB +: HALF] = done;
        return r;
    endfunction : status_byte

    ////////////////////////////////////////////////////////////////////////
    // command decode; zero bits are don't-touch
    always_comb begin
        send_cmd  = '0;
        abort_cmd = '0;
        if (reg_write_in && reg_addr_in == TX_CMD_STATUS_LOWER) begin
            send_cmd[HALF-1:0]  = reg_wdata_in[FLD_SEND_LSB +: HALF];
            abort_cmd[HALF-1:0] = reg_wdata_in[FLD_ABORT_LSB +: HALF];
        end
        if (reg_write_in && reg_addr_in == TX_CMD_STATUS_UPPER) begin
            send_cmd[NUM_BUF-1:HALF]  = reg_wdata_in[FLD_SEND_LSB +: HALF];
            abort_cmd[NUM_BUF-1:HALF] = reg_wdata_in[FLD_ABORT_LSB +: HALF];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scheduling: one start pulse at a time, lowest index first
    always_comb begin
        start_req  = pending & ~tx_active_in;
        grant      = '0;
        next_state = state;
        case (state)
            CANTRS_IDLE: begin
                if (|start_req && ~|tx_active_in) begin
                    grant      = lowest_first(start_req);
                    next_state = CANTRS_SENDING;
                end
            end
            CANTRS_SENDING: begin
                // wait until the engine has dropped every buffer
                if (~|tx_active_in && ~|tx_start) begin
                    next_state = CANTRS_IDLE;
                end
            end
            default: next_state = CANTRS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // per-buffer flags; completion events win over a same-cycle command
    always_comb begin
        next_pending        = pending;
        next_tx_done_flag   = tx_done_flag;
        next_tx_buffer_busy = tx_buffer_busy;
        next_tx_abort       = '0;
        next_tx_start       = grant;
        for (int i = 0; i < NUM_BUF; i++) begin
            // request or due dispatch queues the frame
            if (send_cmd[i] || (auto_dispatch_enable_in[i] && dispatch_due_in[i])) begin
                next_pending[i]      = 1'b1;
                next_tx_done_flag[i] = 1'b0;
            end
            if (grant[i]) begin
                next_pending[i] = 1'b0;
            end
            // abort drops the queued entry; a frame on the bus runs on
            if (abort_cmd[i]) begin
                next_pending[i]  = 1'b0;
                next_tx_abort[i] = tx_active_in[i] | tx_start[i];
                // a grant in the same cycle is withdrawn, so no frame starts
                if (grant[i]) begin
                    next_tx_start[i] = 1'b0;
                end
                if (!tx_active_in[i] && !tx_start[i] && pending[i]) begin
                    next_tx_done_flag[i] = 1'b1;
                end
            end
            if (tx_success_in[i] || tx_abort_done_in[i]) begin
                next_tx_done_flag[i] = 1'b1;
            end
            // busy is the sum of queued, starting and on-bus activity
            // the start pulse itself keeps busy up until the engine answers
            next_tx_buffer_busy[i] = next_pending[i] | next_tx_start[i] | tx_start[i]
                                   | (tx_active_in[i] & ~tx_success_in[i]
                                      & ~tx_abort_done_in[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status read; write data never reflected
    always_comb begin
        next_rdata = rdata;
        if (reg_read_in) begin
            case (reg_addr_in)
                TX_CMD_STATUS_LOWER: next_rdata = status_byte(tx_buffer_busy[HALF-1:0],
                                                              tx_done_flag[HALF-1:0]);
                TX_CMD_STATUS_UPPER: next_rdata = status_byte(tx_buffer_busy[NUM_BUF-1:HALF],
                                                              tx_done_flag[NUM_BUF-1:HALF]);
                default:             next_rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pending        <= '0;
            tx_buffer_busy <= BUSY_RESET;
            tx_done_flag   <= DONE_RESET;
            tx_abort       <= '0;
            tx_start       <= '0;
            rdata          <= '0;
            state          <= CANTRS_IDLE;
        end else begin
            pending        <= next_pending;
            tx_buffer_busy <= next_tx_buffer_busy;
            tx_done_flag   <= next_tx_done_flag;
            tx_abort       <= next_tx_abort;
            tx_start       <= next_tx_start;
            rdata          <= next_rdata;
            state          <= next_state;
        end
    end

    assign reg_rdata_out      = rdata;
    assign tx_start_out       = tx_start;
    assign tx_abort_out       = tx_abort;
    assign tx_buffer_busy_out = tx_buffer_busy;
    assign tx_done_flag_out   = tx_done_flag;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_reset_status;
        @(posedge clk_in) $rose(reset_n_in) |-> tx_done_flag == DONE_RESET && tx_buffer_busy == '0;
    endproperty
    a_reset_status: assert property (p_reset_status) else $error("bad reset status");

    property p_send_busy;
        @(posedge clk_in) disable iff (!reset_n_in)
        (reg_write_in && reg_addr_in == TX_CMD_STATUS_UPPER && reg_wdata_in[3:0] != 4'h0
         && reg_wdata_in[7:4] == 4'h0) |=> |tx_buffer_busy[NUM_BUF-1:HALF];
    endproperty
    a_send_busy: assert property (p_send_busy) else $error("request did not set busy");

    property p_send_clears_done;
        @(posedge clk_in) disable iff (!reset_n_in)
        send_cmd[0] && !tx_success_in[0] && !tx_abort_done_in[0] |=> !tx_done_flag[0];
    endproperty
    a_send_clears_done: assert property (p_send_clears_done) else $error("done not cleared");

    property p_success_done;
        @(posedge clk_in) disable iff (!reset_n_in) tx_success_in[1] |=> tx_done_flag[1];
    endproperty
    a_success_done: assert property (p_success_done) else $error("done not set");

    property p_abort_pulse;
        @(posedge clk_in) disable iff (!reset_n_in)
        |tx_abort |=> (tx_abort & ~$past(abort_cmd)) == '0;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort not self-clearing");

    property p_abort_drops;
        @(posedge clk_in) disable iff (!reset_n_in)
        |(abort_cmd & ~send_cmd & ~dispatch_due_in) |=>
        (pending & $past(abort_cmd & ~send_cmd & ~dispatch_due_in)) == '0;
    endproperty
    a_abort_drops: assert property (p_abort_drops) else $error("abort kept pending");

    property p_priority;
        @(posedge clk_in) disable iff (!reset_n_in)
        tx_start != '0 |-> $onehot(tx_start) && (($past(start_req) & (tx_start - 8'h01)) == '0);
    endproperty
    a_priority: assert property (p_priority) else $error("priority order broken");

    property p_idle_free;
        @(posedge clk_in) disable iff (!reset_n_in)
        !pending[4] && !tx_start[4] && !tx_active_in[4] && !send_cmd[4] && !dispatch_due_in[4]
        ##1 !tx_active_in[4] |-> !tx_buffer_busy[4];
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("busy stuck");

    property p_no_echo;
        @(posedge clk_in) disable iff (!reset_n_in)
        reg_read_in && reg_addr_in == TX_CMD_STATUS_UPPER |=>
        reg_rdata_out == status_byte($past(tx_buffer_busy[7:4]), $past(tx_done_flag[7:4]));
    endproperty
    a_no_echo: assert property (p_no_echo) else $error("read not status");

    c_start: cover property (@(posedge clk_in) disable iff (!reset_n_in) |tx_start);
    c_abort: cover property (@(posedge clk_in) disable iff (!reset_n_in) |tx_abort);
    c_two_pending: cover property (@(posedge clk_in) disable iff (!reset_n_in)
                                   $countones(pending) > 1);
endmodule : cantrs_tx_request_status

/* sim/can_tx_request_status_bench.sv */
`timescale 1ns/1ps
module can_tx_request_status_bench;
    import cantrs_pkg::*;
    logic       clk_in, reset_n_in, wr, rd;
    logic [7:0] addr, wdata, rdata, auto_dispatch_enable, due, start, abrt, act, succ, adone, busy, done, len, v;
    int         err_total, comparisons, cycles;
    cantrs_tx_request_status dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata), .auto_dispatch_enable_in(auto_dispatch_enable), .dispatch_due_in(due),
        .tx_start_out(start), .tx_abort_out(abrt), .tx_active_in(act), .tx_success_in(succ),
        .tx_abort_done_in(adone), .tx_buffer_busy_out(busy), .tx_done_flag_out(done));
    cantrs_engine_model eng_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_in(start),
        .abort_in(abrt), .len_in(len), .active_out(act), .success_out(succ),
        .abort_done_out(adone));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // host side only writes the command/status pair; t_abort also aborts a busy frame
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : reg_rd
    // bounded wait for the next start pulse, then compare it
    task automatic wait_start(input logic [7:0] exp);
        v = 8'h00;
        for (int i = 0; i < 300 && v == 8'h00; i++) begin
            @(posedge clk_in);
            #1 v = start;
        end
        check(v, exp);
    endtask : wait_start
    task automatic wait_idle;
        for (int i = 0; i < 500 && busy !== 8'h00; i++) begin
            @(posedge clk_in);
            #1;
        end
        check(busy, 8'h00);
    endtask : wait_idle
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        reg_rd(TX_CMD_STATUS_UPPER, 8'h0F);
        reg_rd(TX_CMD_STATUS_LOWER, 8'h0F);
        reg_rd(8'h07, 8'h00);
    endtask : t_reset
    task automatic t_request;
        len <= 8'h14;
        reg_wr(TX_CMD_STATUS_UPPER, 8'h01);
        wait_start(8'h10);
        reg_rd(TX_CMD_STATUS_UPPER, 8'h1E);
        reg_wr(TX_CMD_STATUS_UPPER, 8'h00);
        reg_wr(TX_CMD_STATUS_LOWER, 8'h00);
        reg_rd(TX_CMD_STATUS_UPPER, 8'h1E);
        wait_idle();
        check(done, 8'hFF);
        reg_rd(TX_CMD_STATUS_UPPER, 8'h0F);
    endtask : t_request
    // engine held busy by buffer 7 so three requests queue up before the next grant
    task automatic t_priority;
        len <= 8'h0A;
        reg_wr(TX_CMD_STATUS_UPPER, 8'h08);
        wait_start(8'h80);
        reg_wr(TX_CMD_STATUS_UPPER, 8'h01);
        reg_wr(TX_CMD_STATUS_LOWER, 8'h0C);
        wait_start(8'h04);
        wait_start(8'h08);
        wait_start(8'h10);
        wait_idle();
    endtask : t_priority
    // abort is used here on a frame that is taken as failing
    task automatic t_abort;
        len <= 8'h1E;
        reg_wr(TX_CMD_STATUS_LOWER, 8'h01);
        wait_start(8'h01);
        reg_wr(TX_CMD_STATUS_LOWER, 8'h02);
        reg_wr(TX_CMD_STATUS_LOWER, 8'h20);
        reg_rd(TX_CMD_STATUS_LOWER, 8'h1E);
        reg_wr(TX_CMD_STATUS_LOWER, 8'h10);
        // the abort pulse is launched at the edge that takes the write
        #1 check(abrt, 8'h01);
        @(posedge clk_in);
        #1 check(abrt, 8'h00);
        check(act, 8'h01);
        wait_idle();
        reg_rd(TX_CMD_STATUS_LOWER, 8'h0F);
    endtask : t_abort
    task automatic t_dispatch;
        len <= 8'h08;
        auto_dispatch_enable <= 8'h20;
        @(posedge clk_in);
        due <= 8'h20;
        @(posedge clk_in);
        due <= 8'h00;
        wait_start(8'h20);
        reg_rd(TX_CMD_STATUS_UPPER, 8'h2D);
        wait_idle();
        auto_dispatch_enable <= 8'h00;
    endtask : t_dispatch
    ////////////////////////////////////////////////////////////
    // clock, time-zero inputs and the hang guard
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        {reset_n_in, wr, rd, addr, wdata, auto_dispatch_enable, due, len} = '0;
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_request();
        t_priority();
        t_abort();
        t_dispatch();
        tally_and_finish();
    end
endmodule : can_tx_request_status_bench

/* sim/cantrs_engine_model.sv */
`timescale 1ns/1ps
// bit engine stand-in: one frame at a time, length set by the bench
module cantrs_engine_model (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic [7:0] start_in,
    input  wire logic [7:0] abort_in,
    input  wire logic [7:0] len_in,
    output logic      [7:0] active_out,
    output logic      [7:0] success_out,
    output logic      [7:0] abort_done_out
);
    logic [7:0] cnt;
    logic       ab;
    ////////////////////////////////////////////////////////////
    // active rises the cycle after start; an aborted frame runs to its count, then ends as aborted
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_out     <= 8'h00;
            success_out    <= 8'h00;
            abort_done_out <= 8'h00;
            cnt            <= 8'h00;
            ab             <= 1'b0;
        end else begin
            success_out    <= 8'h00;
            abort_done_out <= 8'h00;
            if (|start_in) begin
                active_out <= start_in;
                cnt        <= len_in;
                ab         <= 1'b0;
            end else if (|active_out) begin
                if (|(abort_in & active_out)) ab <= 1'b1;
                if (cnt == 8'h00) begin
                    // no retry once aborted, as the real engine would
                    if (ab || |(abort_in & active_out)) abort_done_out <= active_out;
                    else success_out <= active_out;
                    active_out <= 8'h00;
                end else cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : cantrs_engine_model
